// [ssw_pkg.sv]
// Purpose: shared constants and types of the supply supervisor and watchdog
// Assumes: 250 MHz system clock; supply, switch and kick inputs are asynchronous pins
// Notes:   times are held in their own unit, cycle counts derived from the clock rate
//
// How it works
// - a low manual reset input starts a reset sequence
// - manual reset bounces only restart the hold timer, giving one reset
// - power fail flag is low while the sense input reports under reference
// - kick input steady past the timeout drives watchdog expired low
// - each rising or falling kick edge restarts the watchdog counter
// - watchdog counter held cleared while reset output is asserted
// - floating kick input disables the watchdog entirely
// - supply low or manual reset drives reset low for at least 200 ms
// - reset stays asserted the whole time supply is below threshold
// - reset held 200 ms more after supply recovers or manual reset releases
// - watchdog timeout alone never asserts the reset output
// - watchdog expired stays low until the counter is next cleared
// - supply low forces watchdog expired low regardless of the timer
// - watchdog expired returns high once supply low clears
// - active high reset output is always the complement of active low
// - watchdog timeout is 1.60 s; processor must kick at least that often

`default_nettype none

package ssw_pkg;
    localparam int unsigned CLK_KHZ        = 250_000;
    localparam int unsigned RESET_PULSE_MS = 200;
    localparam int unsigned RESET_CYCLES   = RESET_PULSE_MS * CLK_KHZ;
    // 1.60 s kept in ms so the cycle product stays integral
    localparam int unsigned WD_TIMEOUT_MS  = 1600;
    localparam int unsigned WD_CYCLES      = WD_TIMEOUT_MS * CLK_KHZ;
    localparam int          CNT_W          = 29;

    // synchroniser lanes
    localparam int          NUM_IN         = 5;
    localparam int          IDX_SUPPLY     = 0;
    localparam int          IDX_MR_N       = 1;
    localparam int          IDX_PF         = 2;
    localparam int          IDX_KICK       = 3;
    localparam int          IDX_FLOAT      = 4;
    // supply assumed low and kick floating until the pins are seen
    localparam logic [4:0]  IN_INIT        = 5'h13;

    typedef enum logic [1:0]
    {
        ST_HOLD    = 2'b00,
        ST_STRETCH = 2'b01,
        ST_RUN     = 2'b10
    } ssw_state_e;
endpackage

`default_nettype wire

// [ssw_if.sv]
// Purpose: synchronised input bundle between the input stage and the supervisor
// Assumes: all members are already in the clk_sys domain
// Notes:   manualLow is active high, already inverted from the pin
`timescale 1ns/1ps
`default_nettype none

interface ssw_if;
    logic supplyLow;
    logic manualLow;
    logic pfSense;
    logic kick;
    logic kickFloat;

    modport src (output supplyLow, output manualLow, output pfSense, output kick, output kickFloat);
    modport dst (input supplyLow, input manualLow, input pfSense, input kick, input kickFloat);
endinterface

`default_nettype wire

// [ssw_in_sync.sv]
// Purpose: three-stage synchroniser with agreement filter for every input pin
// Assumes: pins are asynchronous to clk_sys
// Notes:   a lane changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module ssw_in_sync
#(
    parameter int                    W    = ssw_pkg::NUM_IN,
    parameter logic [ssw_pkg::NUM_IN-1:0] INIT = ssw_pkg::IN_INIT
)
(
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstSyncN,
    // raw pins
    input  wire logic [W-1:0] pinIn,
    // synchronised bundle
    ssw_if.src                sig
);
    import ssw_pkg::*;

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] stable_q;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_lane
            always_ff @(posedge clk_sys or negedge rstSyncN)
            begin
                if (!rstSyncN)
                begin
                    s1_q[i]     <= INIT[i];
                    s2_q[i]     <= INIT[i];
                    s3_q[i]     <= INIT[i];
                    stable_q[i] <= INIT[i];
                end
                else
                begin
                    s1_q[i] <= pinIn[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    // s1 feeds only s2; the filter looks at stages two and three
                    if (s2_q[i] == s3_q[i])
                        stable_q[i] <= s3_q[i];
                end
            end
        end
    endgenerate

    assign sig.supplyLow = stable_q[IDX_SUPPLY];
    assign sig.manualLow = ~stable_q[IDX_MR_N];
    assign sig.pfSense   = stable_q[IDX_PF];
    assign sig.kick      = stable_q[IDX_KICK];
    assign sig.kickFloat = stable_q[IDX_FLOAT];

    lane_settle_a: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
        (s2_q == s3_q) |=> (stable_q == $past(s3_q)))
        else $error("synchronised lane did not follow agreeing stages");
endmodule

`default_nettype wire

// [ssw_supervisor.sv]
// Purpose: power-on/manual reset stretcher, watchdog and power fail flag
// Assumes: supply comparison and float detection arrive as logic levels
// Notes:   counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none

module ssw_supervisor
#(
    parameter int unsigned RST_CYCLES = ssw_pkg::RESET_CYCLES,
    parameter int unsigned WDT_CYCLES = ssw_pkg::WD_CYCLES
)
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // supply and manual reset pins
    input  wire logic supply_low,
    input  wire logic manual_reset_in_n,
    // power fail comparator result, high when above reference
    input  wire logic power_fail_sense,
    // watchdog kick and its floating qualifier
    input  wire logic watchdog_kick,
    input  wire logic watchdog_float,
    // outputs to the processor
    output var  logic reset_out_n,
    output var  logic reset_out,
    output var  logic watchdog_expired_n,
    output var  logic power_fail_flag_n
);
    import ssw_pkg::*;

    logic             rstMeta_q;
    logic             rstSyncN;
    logic [NUM_IN-1:0] pinVec;
    ssw_state_e       state_q;
    ssw_state_e       state_d;
    logic [CNT_W-1:0] rstCnt_q;
    logic [CNT_W-1:0] wdCnt_q;
    logic             rstActive_q;
    logic             rstActive_d;
    logic             kickPrev_q;
    logic             kickEdge;
    logic             wdClear;
    logic             wdExpired_q;
    logic             resetTrig;

    ssw_if inSig();

    // release of reset is synchronised; assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_q <= 1'b0;
            rstSyncN  <= 1'b0;
        end
        else
        begin
            rstMeta_q <= 1'b1;
            rstSyncN  <= rstMeta_q;
        end
    end

    always_comb
    begin
        pinVec             = '0;
        pinVec[IDX_SUPPLY] = supply_low;
        pinVec[IDX_MR_N]   = manual_reset_in_n;
        pinVec[IDX_PF]     = power_fail_sense;
        pinVec[IDX_KICK]   = watchdog_kick;
        pinVec[IDX_FLOAT]  = watchdog_float;
    end

    ssw_in_sync #(.W(NUM_IN), .INIT(IN_INIT)) u_sync
    (
        .clk_sys  (clk_sys),
        .rstSyncN (rstSyncN),
        .pinIn    (pinVec),
        .sig      (inSig.src)
    );

    // reset sequencer
    assign resetTrig = inSig.supplyLow | inSig.manualLow;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_HOLD:
                if (!resetTrig)
                    state_d = ST_STRETCH;
            ST_STRETCH:
                if (resetTrig)
                    state_d = ST_HOLD;
                else if (rstCnt_q == CNT_W'(RST_CYCLES - 1))
                    state_d = ST_RUN;
            ST_RUN:
                if (resetTrig)
                    state_d = ST_HOLD;
            default:
                state_d = ST_HOLD;
        endcase
    end

    // the watchdog output is not a trigger here: it only resets when wired back to the manual pin
    assign rstActive_d = (state_d != ST_RUN);

    always_ff @(posedge clk_sys or negedge rstSyncN)
    begin
        if (!rstSyncN)
            state_q <= ST_HOLD;
        else
            state_q <= state_d;
    end

    // bounces re-enter HOLD and restart the stretch, so a switch yields one reset
    always_ff @(posedge clk_sys or negedge rstSyncN)
    begin
        if (!rstSyncN)
            rstCnt_q <= '0;
        else if (state_q != ST_STRETCH || resetTrig)
            rstCnt_q <= '0;
        else
            rstCnt_q <= rstCnt_q + 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            rstActive_q <= 1'b1;
            reset_out_n <= 1'b0;
            reset_out   <= 1'b1;
        end
        else
        begin
            rstActive_q <= rstActive_d;
            reset_out_n <= ~rstActive_d;
            reset_out   <= rstActive_d;
        end
    end

    // watchdog
    assign kickEdge = (inSig.kick != kickPrev_q) && !inSig.kickFloat;
    assign wdClear  = kickEdge | rstActive_q | inSig.kickFloat;

    always_ff @(posedge clk_sys or negedge rstSyncN)
    begin
        if (!rstSyncN)
            kickPrev_q <= 1'b0;
        else
            kickPrev_q <= inSig.kick;
    end

    always_ff @(posedge clk_sys or negedge rstSyncN)
    begin
        if (!rstSyncN)
            wdCnt_q <= '0;
        else if (wdClear)
            wdCnt_q <= '0;
        else if (!wdExpired_q)
            wdCnt_q <= wdCnt_q + 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rstSyncN)
    begin
        if (!rstSyncN)
            wdExpired_q <= 1'b0;
        else if (wdClear)
            wdExpired_q <= 1'b0;
        else if (wdCnt_q == CNT_W'(WDT_CYCLES - 1))
            wdExpired_q <= 1'b1;
    end

    // low line forces the output low over the timer; once supply recovers the output follows the timer
    always_ff @(posedge clk_sys or negedge rstSyncN)
    begin
        if (!rstSyncN)
            watchdog_expired_n <= 1'b0;
        else
            watchdog_expired_n <= ~(wdExpired_q | inSig.supplyLow);
    end

    always_ff @(posedge clk_sys or negedge rstSyncN)
    begin
        if (!rstSyncN)
            power_fail_flag_n <= 1'b0;
        else
            power_fail_flag_n <= inSig.pfSense;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstSyncN);

    reset_complement_a: assert property (reset_out == ~reset_out_n)
        else $error("reset outputs not complementary");
    trigger_reset_a: assert property (resetTrig |=> !reset_out_n)
        else $error("trigger did not assert reset");
    supply_hold_a: assert property (inSig.supplyLow [*2] |-> !reset_out_n)
        else $error("reset released while supply low");
    stretch_len_a: assert property ($rose(reset_out_n) |-> $past(rstCnt_q) == CNT_W'(RST_CYCLES - 1))
        else $error("reset released before full hold time");
    bounce_restart_a: assert property (inSig.manualLow |=> rstCnt_q == '0)
        else $error("manual reset bounce did not restart hold");
    wd_held_a: assert property (!reset_out_n |=> wdCnt_q == '0)
        else $error("watchdog counted during reset");
    kick_clear_a: assert property (kickEdge |=> wdCnt_q == '0 && !wdExpired_q)
        else $error("kick edge did not clear watchdog");
    float_disable_a: assert property (inSig.kickFloat |=> wdCnt_q == '0 && !wdExpired_q)
        else $error("watchdog ran while kick floating");
    wd_expire_a: assert property (!wdClear && wdCnt_q == CNT_W'(WDT_CYCLES - 1) |=> wdExpired_q ##1 !watchdog_expired_n)
        else $error("watchdog did not expire at timeout");
    expired_hold_a: assert property (wdExpired_q && !wdClear |=> wdExpired_q)
        else $error("expired flag dropped without clear");
    low_line_a: assert property (inSig.supplyLow |=> !watchdog_expired_n)
        else $error("supply low did not force watchdog output low");
    line_ok_a: assert property (!inSig.supplyLow && !wdExpired_q |=> watchdog_expired_n)
        else $error("watchdog output stuck low after supply recovered");
    no_wd_reset_a: assert property (state_q == ST_RUN && !resetTrig && wdExpired_q |=> reset_out_n)
        else $error("watchdog timeout asserted reset");
    pf_follow_a: assert property (power_fail_flag_n == $past(inSig.pfSense))
        else $error("power fail flag does not follow comparator");

    release_c: cover property ($rose(reset_out_n));
    expire_c: cover property ($fell(watchdog_expired_n) && !inSig.supplyLow);
    kick_c: cover property (kickEdge && reset_out_n);
    manual_c: cover property ($rose(inSig.manualLow) && reset_out_n);
endmodule

`default_nettype wire

// [ssw_cpu_model.sv]
// Purpose: processor model that services the watchdog kick line
// Assumes: kick toggles only while enabled and out of reset
// Notes:   PERIOD must stay below the watchdog count to avoid expiry
`timescale 1ns/1ps
`default_nettype none

module ssw_cpu_model
#(
    parameter int unsigned PERIOD = 20
)
(
    // clock
    input  wire logic clk_sys,
    // firmware control and reset seen by the processor
    input  wire logic enable,
    input  wire logic reset_out_n,
    // kick line
    output var  logic watchdog_kick
);
    int unsigned tick;

    initial watchdog_kick = 1'b0;
    initial tick = 0;

    // firmware is halted in reset, so the kick loop restarts after release
    always @(posedge clk_sys)
    begin
        if (!enable || !reset_out_n)
            tick <= 0;
        else if (tick == PERIOD - 1)
        begin
            tick <= 0;
            watchdog_kick <= #1 ~watchdog_kick;
        end
        else
            tick <= tick + 1;
    end
endmodule

`default_nettype wire

// [testbench.sv]
// Purpose: self-checking bench of the supply supervisor and watchdog
// Assumes: shortened counts; pin to output latency of about five edges
// Notes:   event windows allow a few edges of synchroniser slack
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int RST = 20;
    localparam int WDT = 50;
    localparam int KICK_P = 20;

    typedef struct { int kind; int lo; int hi; } ssw_note_s;

    logic clk_sys = 1'b0;
    logic rstN = 1'b0;
    logic supplyLow = 1'b1;
    logic mrN = 1'b1;
    logic pfSense = 1'b0;
    logic wdFloat = 1'b1;
    logic cpuEn = 1'b0;
    logic kick;
    logic resetOutN;
    logic resetOut;
    logic wdExpN;
    logic pfFlagN;
    logic lastRst = 1'b0;
    logic lastWdo = 1'b0;
    int cyc = 0;
    int failures = 0;
    int checksDone = 0;
    ssw_note_s notes[$];

    always #2 clk_sys = ~clk_sys;

    ssw_supervisor #(.RST_CYCLES(RST), .WDT_CYCLES(WDT)) dut
    (
        .clk_sys(clk_sys), .rst_n(rstN), .supply_low(supplyLow), .manual_reset_in_n(mrN),
        .power_fail_sense(pfSense), .watchdog_kick(kick), .watchdog_float(wdFloat),
        .reset_out_n(resetOutN), .reset_out(resetOut), .watchdog_expired_n(wdExpN),
        .power_fail_flag_n(pfFlagN)
    );

    ssw_cpu_model #(.PERIOD(KICK_P)) cpu
    (
        .clk_sys(clk_sys), .enable(cpuEn), .reset_out_n(resetOutN), .watchdog_kick(kick)
    );

    task automatic summarize();
        if (failures == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic checkBit(input logic got, input logic exp, input string msg);
        checksDone++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic checkEvent(input int kind);
        ssw_note_s n;
        checksDone++;
        if (notes.size() == 0)
        begin
            failures++;
            $display("[FAIL] %0t unexpected event kind %0d", $time, kind);
        end
        else
        begin
            n = notes.pop_front();
            if (n.kind != kind || cyc < n.lo || cyc > n.hi)
            begin
                failures++;
                $display("[FAIL] %0t event kind %0d at cycle %0d", $time, kind, cyc);
            end
        end
    endtask

    task automatic expectAt(input int kind, input int lo, input int hi);
        ssw_note_s n;
        n.kind = kind;
        n.lo = lo;
        n.hi = hi;
        notes.push_back(n);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic waitQueue(input int limit);
        int i;
        for (i = 0; i < limit && notes.size() != 0; i++)
            step(1);
        if (notes.size() != 0)
        begin
            failures++;
            $display("[FAIL] %0t expected event never came", $time);
            summarize();
        end
    endtask

    // watcher: sample well after the edge so registered outputs have settled
    always @(posedge clk_sys)
    begin
        #2;
        cyc++;
        if (rstN && resetOutN === 1'b1 && lastRst === 1'b0)
            checkEvent(0);
        if (rstN && wdExpN === 1'b0 && lastWdo === 1'b1)
            checkEvent(1);
        lastRst = resetOutN;
        lastWdo = wdExpN;
        checkBit(resetOut, ~resetOutN, "active high reset not complement");
    end

    initial
    begin
        void'($urandom(80507));
        step(16);
        rstN = 1'b1;
        supplyLow = 1'b0;
        expectAt(0, cyc + RST, cyc + RST + 10);
        waitQueue(200);
        wdFloat = 1'b0;
        expectAt(1, cyc + WDT + 1, cyc + WDT + 9);
        waitQueue(200);
        checkBit(resetOutN, 1'b1, "timeout asserted reset");
        step(20);
        checkBit(wdExpN, 1'b0, "expired output released early");
        cpuEn = 1'b1;
        step(KICK_P + 10);
        checkBit(wdExpN, 1'b1, "kick did not clear expiry");
        step(4 * WDT);
        cpuEn = 1'b0;
        wdFloat = 1'b1;
        step(3 * WDT);
        checkBit(wdExpN, 1'b1, "floating kick still timed out");
        mrN = 1'b0;
        step(8);
        checkBit(resetOutN, 1'b0, "manual reset ignored");
        repeat (4)
        begin
            mrN = 1'b1;
            step(1 + $urandom % 6);
            mrN = 1'b0;
            // a one-cycle low is filtered out and would start the hold earlier than expected
            step(2 + $urandom % 5);
        end
        mrN = 1'b1;
        expectAt(0, cyc + RST + 2, cyc + RST + 9);
        waitQueue(200);
        supplyLow = 1'b1;
        // watchdog armed but never kicked: only the reset hold keeps it from expiring
        wdFloat = 1'b0;
        expectAt(1, cyc + 2, cyc + 8);
        step(3 * RST);
        checkBit(resetOutN, 1'b0, "reset released with supply low");
        supplyLow = 1'b0;
        expectAt(0, cyc + RST + 2, cyc + RST + 9);
        step(8);
        checkBit(wdExpN, 1'b1, "expired output stuck after supply recovery");
        waitQueue(200);
        expectAt(1, cyc + WDT, cyc + WDT + 3);
        repeat (8)
        begin
            pfSense = 1'($urandom % 2);
            step(7);
            checkBit(pfFlagN, pfSense, "power fail flag wrong");
        end
        waitQueue(200);
        summarize();
    end
endmodule

`default_nettype wire
